/* File: logic/uart_ext_pkg.sv */
package uart_ext_pkg;
	localparam logic [7:0] OFF_TX_HOLD             = 8'h00;
	localparam logic [7:0] OFF_SHADOW_TX_HOLD      = 8'h6c;
	localparam logic [7:0] OFF_FIFO_TEST_ACCESS    = 8'h70;
	localparam logic [7:0] OFF_TX_FIFO_READBACK    = 8'h74;
	localparam logic [7:0] OFF_RX_FIFO_INJECT      = 8'h78;
	localparam logic [7:0] OFF_UART_STATUS_FLAGS   = 8'h7c;
	localparam logic [7:0] OFF_TX_FIFO_LEVEL       = 8'h80;
	localparam logic [7:0] OFF_RX_FIFO_LEVEL       = 8'h84;
	localparam logic [7:0] OFF_SOFT_RESET_CTRL     = 8'h88;
	localparam logic [7:0] OFF_SHADOW_RTS          = 8'h8c;
	localparam logic [7:0] OFF_SHADOW_BREAK        = 8'h90;
	localparam logic [7:0] OFF_SHADOW_DMA_MODE     = 8'h94;
	localparam logic [7:0] OFF_SHADOW_FIFO_ENABLE  = 8'h98;
	localparam logic [7:0] OFF_SHADOW_RX_TRIGGER   = 8'h9c;
	localparam logic [7:0] OFF_SHADOW_TX_EMPTY_TRG = 8'ha0;
	localparam logic [7:0] OFF_HALT_TRANSMIT       = 8'ha4;
	localparam logic [7:0] OFF_DMA_SOFT_ACK        = 8'ha8;
	localparam logic [7:0] OFF_COMPONENT_PARAMS    = 8'hf4;
	localparam logic [7:0] OFF_COMPONENT_VERSION   = 8'hf8;
	localparam logic [7:0] OFF_PERIPHERAL_IDENT    = 8'hfc;
	localparam int BIT_RX_FULL      = 4;
	localparam int BIT_RX_NOT_EMPTY = 3;
	localparam int BIT_TX_EMPTY     = 2;
	localparam int BIT_TX_NOT_FULL  = 1;
	localparam int BIT_BUSY         = 0;
	localparam int BIT_FRAME_ERR    = 9;
	localparam int BIT_PARITY_ERR   = 8;
	localparam int BIT_SRR_UART     = 0;
	localparam int BIT_SRR_RX       = 1;
	localparam int BIT_SRR_TX       = 2;
	localparam int FIFO_WIDTH       = 8;
	localparam int RX_ENTRY_WIDTH   = 10;
	localparam int FIFO_DEPTH       = 16;
	localparam int LEVEL_WIDTH      = 5;
	localparam int TRIG_WIDTH       = 2;
	// arbitrary neutral identity values
	localparam logic [31:0] VERSION_DEFAULT = 32'h30303030;
	localparam logic [31:0] IDENT_DEFAULT   = 32'h00000001;
	localparam logic [31:0] PARAMS_DEFAULT  = 32'h00010000;
endpackage : uart_ext_pkg

/* File: logic/uart_ext_fifo.sv */
`timescale 1ns/1ps
module uart_ext_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LVLW  = 5
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic             flush,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	// status
	output logic [LVLW-1:0]       level
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0]   wptr;
		logic [AW-1:0]   rptr;
		logic [LVLW-1:0] cnt;
	} fifo_state_t;
	fifo_state_t     st_reg;
	fifo_state_t     st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic            push;
	logic            pop;

	assign in_ready  = (st_reg.cnt != LVLW'(DEPTH));
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = mem[st_reg.rptr];
	assign level     = st_reg.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.wptr = AW'(st_reg.wptr + 1'b1);
		end
		if (pop) begin
			st_next.rptr = AW'(st_reg.rptr + 1'b1);
		end
		st_next.cnt = LVLW'(st_reg.cnt + LVLW'(push) - LVLW'(pop));
		if (flush) begin
			st_next = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
		if (push && !flush) begin
			mem[st_reg.wptr] <= in_data;
		end
	end
endmodule : uart_ext_fifo

/* File: logic/uart_shadow_status_test_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - test mode with fifos on: host pushes receive fifo, pops transmit fifo.
// - test mode with fifos off: writes load receive buffer, reads return holding register.
// - readback read in test mode with fifos on returns transmit fifo head byte and pops it; outside test mode it reads zero.
// - test mode with fifos on, inject write pushes byte plus framing bit 9 and parity bit 8.
// - test mode with fifos off, inject write lands in receive buffer register.
// - status bit 4 high while receive fifo is full.
// - status bit 3 high while receive fifo holds any entry.
// - status bit 2 high while transmit fifo empty, resets to one.
// - status bit 1 high while transmit fifo not full, resets to one.
// - status bit 0 high while a serial transfer runs.
// - transmit level field gives transmit fifo entry count.
// - receive level field gives receive fifo entry count.
// - soft reset bit 0 resets the whole uart.
// - soft reset bits 2 and 1 flush transmit and receive fifos.
// - shadow rts shares storage with modem control rts bit.
// - shadow break shares storage with line control break bit.
// - shadow dma mode shares storage with fifo control dma bit.
// - shadow fifo enable shares storage with fifo control enable bit.
// - shadow trigger fields share fifo control trigger bits.
// - halt transmit stops new serial transmissions starting.
// - dma soft ack write gives a dma acknowledge pulse.
// - shadow holding location reads holding register storage.
// - read-only identification and version words.
// - line settings writable only while not busy.
module uart_shadow_status_test_regs #(
	parameter logic [31:0] VERSION_WORD = uart_ext_pkg::VERSION_DEFAULT,
	parameter logic [31:0] IDENT_WORD   = uart_ext_pkg::IDENT_DEFAULT,
	parameter logic [31:0] PARAMS_WORD  = uart_ext_pkg::PARAMS_DEFAULT
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// register port
	input  wire logic        reg_sel,
	input  wire logic        reg_write,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata,
	// base register side effects
	input  wire logic        base_line_wr,
	input  wire logic [5:0]  base_line_wdata,
	input  wire logic        base_fcr_tx_flush,
	input  wire logic        base_fcr_rx_flush,
	// serial engine side
	input  wire logic        tx_busy,
	input  wire logic        rx_busy,
	input  wire logic        tx_take,
	output logic             tx_start_ok,
	output logic [7:0]       tx_head,
	output logic             tx_head_valid,
	// control outputs
	output logic             rts_ctrl,
	output logic             break_ctrl,
	output logic             dma_mode,
	output logic             fifo_enable,
	output logic [1:0]       rx_trigger,
	output logic [1:0]       tx_empty_trigger,
	output logic [5:0]       line_settings,
	output logic             dma_ack,
	output logic             uart_reset_out,
	output logic [7:0]       rx_buf_data,
	output logic [1:0]       rx_buf_err
);
	typedef struct packed {
		logic        test_en;
		logic        rts;
		logic        brk;
		logic        dmam;
		logic        fen;
		logic [1:0]  rtrig;
		logic [1:0]  ttrig;
		logic        halt;
		logic [5:0]  line;
		logic [7:0]  thr;
		logic [9:0]  rbr;
		logic        dack;
		logic        urst;
		logic        start_ok;
		logic [7:0]  head;
		logic        head_v;
		logic [31:0] rdata;
	} regs_state_t;
	regs_state_t st_reg;
	regs_state_t st_next;

	logic                                      wr;
	logic                                      rd;
	logic                                      tx_flush;
	logic                                      rx_flush;
	logic                                      tx_in_valid;
	logic                                      tx_in_ready;
	logic                                      tx_out_valid;
	logic [uart_ext_pkg::FIFO_WIDTH-1:0]       tx_out_data;
	logic                                      tx_pop;
	logic [uart_ext_pkg::LEVEL_WIDTH-1:0]      tx_level;
	logic                                      rx_in_valid;
	logic                                      rx_in_ready;
	logic                                      rx_out_valid;
	logic [uart_ext_pkg::RX_ENTRY_WIDTH-1:0]   rx_out_data;
	logic [uart_ext_pkg::LEVEL_WIDTH-1:0]      rx_level;
	logic [4:0]                                status;
	logic                                      busy;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	assign wr       = reg_sel && reg_write;
	assign rd       = reg_sel && !reg_write;
	assign busy     = tx_busy || rx_busy;
	assign tx_flush = base_fcr_tx_flush || st_reg.urst ||
		(wr && hit(reg_addr, uart_ext_pkg::OFF_SOFT_RESET_CTRL) && reg_wdata[uart_ext_pkg::BIT_SRR_TX]);
	assign rx_flush = base_fcr_rx_flush || st_reg.urst ||
		(wr && hit(reg_addr, uart_ext_pkg::OFF_SOFT_RESET_CTRL) && reg_wdata[uart_ext_pkg::BIT_SRR_RX]);
	// holding register writes feed the transmit fifo while fifos are on
	assign tx_in_valid = st_reg.fen && wr && hit(reg_addr, uart_ext_pkg::OFF_TX_HOLD);
	assign tx_pop = (st_reg.test_en && st_reg.fen && rd
		&& hit(reg_addr, uart_ext_pkg::OFF_TX_FIFO_READBACK))
		|| (!st_reg.test_en && tx_take && !st_reg.halt);
	assign rx_in_valid = st_reg.test_en && st_reg.fen && wr
		&& hit(reg_addr, uart_ext_pkg::OFF_RX_FIFO_INJECT);

	uart_ext_fifo #(
		.WIDTH (uart_ext_pkg::FIFO_WIDTH),
		.DEPTH (uart_ext_pkg::FIFO_DEPTH),
		.LVLW  (uart_ext_pkg::LEVEL_WIDTH)
	) tx_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.flush     (tx_flush),
		.in_valid  (tx_in_valid),
		.in_data   (reg_wdata[uart_ext_pkg::FIFO_WIDTH-1:0]),
		.in_ready  (tx_in_ready),
		.out_valid (tx_out_valid),
		.out_data  (tx_out_data),
		.out_ready (tx_pop),
		.level     (tx_level)
	);

	uart_ext_fifo #(
		.WIDTH (uart_ext_pkg::RX_ENTRY_WIDTH),
		.DEPTH (uart_ext_pkg::FIFO_DEPTH),
		.LVLW  (uart_ext_pkg::LEVEL_WIDTH)
	) rx_fifo (
		.mclk      (mclk),
		.reset     (reset),
		.flush     (rx_flush),
		.in_valid  (rx_in_valid),
		.in_data   (reg_wdata[uart_ext_pkg::BIT_FRAME_ERR:0]),
		.in_ready  (rx_in_ready),
		.out_valid (rx_out_valid),
		.out_data  (rx_out_data),
		.out_ready (1'b0),
		.level     (rx_level)
	);

	always_comb begin
		status = '0;
		status[uart_ext_pkg::BIT_RX_FULL]      = !rx_in_ready;
		status[uart_ext_pkg::BIT_RX_NOT_EMPTY] = rx_out_valid;
		status[uart_ext_pkg::BIT_TX_EMPTY]     = !tx_out_valid;
		status[uart_ext_pkg::BIT_TX_NOT_FULL]  = tx_in_ready;
		status[uart_ext_pkg::BIT_BUSY]         = busy;
	end

	always_comb begin
		st_next          = st_reg;
		st_next.dack     = 1'b0;
		st_next.urst     = 1'b0;
		st_next.start_ok = !st_reg.halt && !st_reg.test_en;
		st_next.head     = tx_out_valid ? tx_out_data : 8'h00;
		st_next.head_v   = tx_out_valid;
		// receive buffer outputs show the receive fifo head while fifos are on
		if (st_reg.fen && rx_out_valid) begin
			st_next.rbr = rx_out_data;
		end
		if (base_line_wr && !busy) begin
			st_next.line = base_line_wdata;
		end
		if (wr) begin
			case (reg_addr)
				uart_ext_pkg::OFF_TX_HOLD: st_next.thr = reg_wdata[7:0];
				uart_ext_pkg::OFF_FIFO_TEST_ACCESS: st_next.test_en = reg_wdata[0];
				uart_ext_pkg::OFF_RX_FIFO_INJECT: begin
					if (st_reg.test_en && !st_reg.fen) begin
						st_next.rbr = reg_wdata[uart_ext_pkg::BIT_FRAME_ERR:0];
					end
				end
				uart_ext_pkg::OFF_SOFT_RESET_CTRL: st_next.urst = reg_wdata[uart_ext_pkg::BIT_SRR_UART];
				uart_ext_pkg::OFF_SHADOW_RTS: st_next.rts = reg_wdata[0];
				uart_ext_pkg::OFF_SHADOW_BREAK: st_next.brk = reg_wdata[0];
				uart_ext_pkg::OFF_SHADOW_DMA_MODE: st_next.dmam = reg_wdata[0];
				uart_ext_pkg::OFF_SHADOW_FIFO_ENABLE: st_next.fen = reg_wdata[0];
				uart_ext_pkg::OFF_SHADOW_RX_TRIGGER: st_next.rtrig = reg_wdata[1:0];
				uart_ext_pkg::OFF_SHADOW_TX_EMPTY_TRG: st_next.ttrig = reg_wdata[1:0];
				uart_ext_pkg::OFF_HALT_TRANSMIT: st_next.halt = reg_wdata[0];
				uart_ext_pkg::OFF_DMA_SOFT_ACK: st_next.dack = reg_wdata[0];
				default: st_next.rdata = st_reg.rdata;
			endcase
		end
		st_next.rdata = '0;
		if (rd) begin
			case (reg_addr)
				uart_ext_pkg::OFF_SHADOW_TX_HOLD: st_next.rdata[7:0] = st_reg.thr;
				uart_ext_pkg::OFF_FIFO_TEST_ACCESS: st_next.rdata[0] = st_reg.test_en;
				uart_ext_pkg::OFF_TX_FIFO_READBACK: begin
					if (st_reg.test_en) begin
						st_next.rdata[7:0] = st_reg.fen ? (tx_out_valid ? tx_out_data : 8'h00) : st_reg.thr;
					end
				end
				uart_ext_pkg::OFF_UART_STATUS_FLAGS: st_next.rdata[4:0] = status;
				uart_ext_pkg::OFF_TX_FIFO_LEVEL: st_next.rdata[4:0] = tx_level;
				uart_ext_pkg::OFF_RX_FIFO_LEVEL: st_next.rdata[4:0] = rx_level;
				uart_ext_pkg::OFF_SHADOW_RTS: st_next.rdata[0] = st_reg.rts;
				uart_ext_pkg::OFF_SHADOW_BREAK: st_next.rdata[0] = st_reg.brk;
				uart_ext_pkg::OFF_SHADOW_DMA_MODE: st_next.rdata[0] = st_reg.dmam;
				uart_ext_pkg::OFF_SHADOW_FIFO_ENABLE: st_next.rdata[0] = st_reg.fen;
				uart_ext_pkg::OFF_SHADOW_RX_TRIGGER: st_next.rdata[1:0] = st_reg.rtrig;
				uart_ext_pkg::OFF_SHADOW_TX_EMPTY_TRG: st_next.rdata[1:0] = st_reg.ttrig;
				uart_ext_pkg::OFF_HALT_TRANSMIT: st_next.rdata[0] = st_reg.halt;
				uart_ext_pkg::OFF_COMPONENT_PARAMS: st_next.rdata = PARAMS_WORD;
				uart_ext_pkg::OFF_COMPONENT_VERSION: st_next.rdata = VERSION_WORD;
				uart_ext_pkg::OFF_PERIPHERAL_IDENT: st_next.rdata = IDENT_WORD;
				default: st_next.rdata = '0;
			endcase
		end
		if (st_reg.urst) begin
			st_next = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata        = st_reg.rdata;
	assign tx_start_ok      = st_reg.start_ok;
	assign tx_head          = st_reg.head;
	assign tx_head_valid    = st_reg.head_v;
	assign rts_ctrl         = st_reg.rts;
	assign break_ctrl       = st_reg.brk;
	assign dma_mode         = st_reg.dmam;
	assign fifo_enable      = st_reg.fen;
	assign rx_trigger       = st_reg.rtrig;
	assign tx_empty_trigger = st_reg.ttrig;
	assign line_settings    = st_reg.line;
	assign dma_ack          = st_reg.dack;
	assign uart_reset_out   = st_reg.urst;
	assign rx_buf_data      = st_reg.rbr[7:0];
	assign rx_buf_err       = st_reg.rbr[uart_ext_pkg::BIT_FRAME_ERR:uart_ext_pkg::BIT_PARITY_ERR];

	a_status_tx_empty: assert property (@(posedge mclk) disable iff (reset)
		(tx_level == '0) |-> status[uart_ext_pkg::BIT_TX_EMPTY]) else $error("tx empty flag wrong");
	a_status_rx_ne: assert property (@(posedge mclk) disable iff (reset)
		(rx_level != '0) |-> status[uart_ext_pkg::BIT_RX_NOT_EMPTY]) else $error("rx not empty flag wrong");
	a_rx_full_flag: assert property (@(posedge mclk) disable iff (reset)
		status[uart_ext_pkg::BIT_RX_FULL] |-> rx_level == 5'h10) else $error("rx full flag wrong");
	a_tx_not_full: assert property (@(posedge mclk) disable iff (reset)
		!status[uart_ext_pkg::BIT_TX_NOT_FULL] |-> tx_level == 5'h10) else $error("tx not full flag wrong");
	a_busy_flag: assert property (@(posedge mclk) disable iff (reset)
		status[uart_ext_pkg::BIT_BUSY] == (tx_busy || rx_busy)) else $error("busy flag wrong");
	a_inject_push: assert property (@(posedge mclk) disable iff (reset || rx_flush)
		rx_in_valid && rx_in_ready |=> rx_level == $past(rx_level) + 5'h01) else $error("inject not pushed");
	a_dma_ack_pulse: assert property (@(posedge mclk) disable iff (reset)
		wr && reg_addr == uart_ext_pkg::OFF_DMA_SOFT_ACK && reg_wdata[0] && !st_reg.urst |=> dma_ack ##1 !dma_ack)
		else $error("dma ack not pulsed");
	a_line_guard: assert property (@(posedge mclk) disable iff (reset)
		busy && !st_reg.urst |=> $stable(line_settings)) else $error("line changed while busy");
	a_halt_blocks: assert property (@(posedge mclk) disable iff (reset)
		st_reg.halt |=> !tx_start_ok) else $error("start allowed while halted");
endmodule : uart_shadow_status_test_regs

/* File: test/uart_serial_peer.sv */
`timescale 1ns/1ps
module uart_serial_peer #(
	parameter int RX_LEN = 40,
	parameter int TX_LEN = 20
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// bench command
	input  wire logic rx_go,
	// engine handshake
	input  wire logic tx_start_ok,
	input  wire logic tx_head_valid,
	output logic      tx_take,
	output logic      tx_busy,
	output logic      rx_busy
);
	int   rx_cnt   = 0;
	int   tx_cnt   = 0;
	logic take_reg = 1'b0;
	always @(posedge mclk) begin
		take_reg <= 1'b0;
		if (reset) begin
			rx_cnt <= 0;
			tx_cnt <= 0;
		end else begin
			if (rx_go) begin
				rx_cnt <= RX_LEN;
			end else if (rx_cnt > 0) begin
				rx_cnt <= rx_cnt - 1;
			end
			if (tx_cnt > 0) begin
				tx_cnt <= tx_cnt - 1;
			end else if (tx_start_ok && tx_head_valid) begin
				take_reg <= 1'b1;
				tx_cnt   <= TX_LEN;
			end
		end
	end
	assign tx_take = take_reg;
	assign rx_busy = rx_cnt != 0;
	assign tx_busy = tx_cnt != 0;
endmodule : uart_serial_peer

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] ver_word = 32'h31303061; // arbitrary value
	localparam logic [31:0] id_word  = 32'h00005a01; // arbitrary value
	localparam logic [31:0] par_word = 32'h00000102;
	logic        mclk, reset, reg_sel, reg_write, rx_go, busy;
	logic        base_line_wr, base_fcr_tx_flush, base_fcr_rx_flush;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, v;
	logic [5:0]  base_line_wdata, line_settings;
	logic        tx_busy, rx_busy, tx_take, tx_start_ok, tx_head_valid;
	logic        rts_ctrl, break_ctrl, dma_mode, fifo_enable, dma_ack, uart_reset_out;
	logic [1:0]  rx_trigger, tx_empty_trigger, rx_buf_err;
	logic [7:0]  rx_buf_data, tx_head;
	logic [9:0]  rxq[$];
	logic [7:0]  txq[$];
	logic [7:0]  sa[7] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4};
	logic [31:0] sm[7] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h3, 32'h3, 32'h1};
	int          fails, checks;

	always #25 mclk = ~mclk;

	uart_shadow_status_test_regs #(.VERSION_WORD(ver_word), .IDENT_WORD(id_word), .PARAMS_WORD(par_word)) i_dut (
		.mclk(mclk), .reset(reset), .reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .base_line_wr(base_line_wr),
		.base_line_wdata(base_line_wdata), .base_fcr_tx_flush(base_fcr_tx_flush),
		.base_fcr_rx_flush(base_fcr_rx_flush), .tx_busy(tx_busy), .rx_busy(rx_busy), .tx_take(tx_take),
		.tx_start_ok(tx_start_ok), .tx_head(tx_head), .tx_head_valid(tx_head_valid), .rts_ctrl(rts_ctrl),
		.break_ctrl(break_ctrl), .dma_mode(dma_mode), .fifo_enable(fifo_enable), .rx_trigger(rx_trigger),
		.tx_empty_trigger(tx_empty_trigger), .line_settings(line_settings), .dma_ack(dma_ack),
		.uart_reset_out(uart_reset_out), .rx_buf_data(rx_buf_data), .rx_buf_err(rx_buf_err));

	uart_serial_peer i_peer (.mclk(mclk), .reset(reset), .rx_go(rx_go), .tx_start_ok(tx_start_ok),
		.tx_head_valid(tx_head_valid), .tx_take(tx_take), .tx_busy(tx_busy), .rx_busy(rx_busy));

	task automatic stop_test;
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] x);
		@(posedge mclk);
		reg_sel   <= 1'b1;
		reg_write <= w;
		reg_addr  <= a;
		reg_wdata <= x;
		@(posedge mclk);
		reg_sel <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		acc(1'b1, a, x);
	endtask : wr

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(name, d, exp);
	endtask : rchk

	task automatic line_wr(input logic [5:0] x);
		@(posedge mclk);
		base_line_wr    <= 1'b1;
		base_line_wdata <= x;
		@(posedge mclk);
		base_line_wr <= 1'b0;
		#1;
	endtask : line_wr

	task automatic wait_busy(input logic want);
		int n;
		n = 0;
		acc(1'b0, 8'h7c, 32'h0);
		while (d[0] !== want && n < 100) begin
			acc(1'b0, 8'h7c, 32'h0);
			n++;
		end
		if (n == 100) begin
			fails++;
			stop_test();
		end
	endtask : wait_busy

	function automatic logic [31:0] exp_status();
		return {27'h0, rxq.size() == 16, rxq.size() != 0, txq.size() == 0, txq.size() != 16, busy};
	endfunction : exp_status

	function automatic logic [31:0] ctl_out(input int i);
		case (i)
			0: return {31'h0, rts_ctrl};
			1: return {31'h0, break_ctrl};
			2: return {31'h0, dma_mode};
			3: return {31'h0, fifo_enable};
			4: return {30'h0, rx_trigger};
			5: return {30'h0, tx_empty_trigger};
			default: return {31'h0, ~tx_start_ok};
		endcase
	endfunction : ctl_out

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		{reg_sel, reg_write, rx_go, busy, base_line_wr, base_fcr_tx_flush, base_fcr_rx_flush} = '0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		base_line_wdata = 6'h00;
		fails = 0;
		checks = 0;
		v = $urandom(80);
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("start_ok", tx_start_ok, 1);
		rchk("status", 8'h7c, exp_status());
		rchk("tx_level", 8'h80, 0);
		rchk("rx_level", 8'h84, 0);
		rchk("hold", 8'h6c, 0);
		rchk("version", 8'hf8, ver_word);
		rchk("ident", 8'hfc, id_word);
		rchk("params", 8'hf4, par_word);
		rchk("unmapped", 8'h40, 0);
		for (int i = 0; i < 7; i++) begin
			v = $urandom();
			wr(sa[i], v);
			rchk("shadow", sa[i], v & sm[i]);
			chk("shadow_out", ctl_out(i), v & sm[i]);
		end
		wr(8'ha4, 1);
		wr(8'h98, 1);
		wr(8'h78, 32'h155);
		rchk("rx_level", 8'h84, 0);
		for (int i = 0; i < 17; i++) begin
			v = $urandom();
			wr(8'h00, v);
			if (txq.size() < 16) begin
				txq.push_back(v[7:0]);
			end
			rchk("hold", 8'h6c, v[7:0]);
			rchk("tx_level", 8'h80, txq.size());
			rchk("status", 8'h7c, exp_status());
		end
		chk("start_ok", tx_start_ok, 0);
		chk("tx_head", tx_head, txq[0]);
		chk("head_valid", tx_head_valid, 1);
		rchk("readback", 8'h74, 0);
		wr(8'h70, 1);
		for (int i = 0; i < 17; i++) begin
			v = $urandom();
			wr(8'h78, v);
			if (rxq.size() < 16) begin
				rxq.push_back(v[9:0]);
			end
			rchk("rx_level", 8'h84, rxq.size());
			rchk("status", 8'h7c, exp_status());
		end
		chk("rx_head", {22'h0, rx_buf_err, rx_buf_data}, rxq[0]);
		for (int i = 0; i < 16; i++) begin
			rchk("readback", 8'h74, txq.pop_front());
		end
		rchk("tx_level", 8'h80, 0);
		rchk("empty_read", 8'h74, 0);
		wr(8'h88, 32'h2);
		rxq.delete();
		rchk("rx_level", 8'h84, 0);
		rchk("status", 8'h7c, exp_status());
		wr(8'h78, 32'h0aa);
		wr(8'h00, 32'h5a);
		wr(8'h00, 32'ha5);
		@(posedge mclk);
		base_fcr_rx_flush <= 1'b1;
		@(posedge mclk);
		base_fcr_rx_flush <= 1'b0;
		rchk("rx_level", 8'h84, 0);
		rchk("tx_level", 8'h80, 2);
		wr(8'h88, 32'h4);
		rchk("tx_level", 8'h80, 0);
		wr(8'h00, 32'h3c);
		@(posedge mclk);
		base_fcr_tx_flush <= 1'b1;
		@(posedge mclk);
		base_fcr_tx_flush <= 1'b0;
		rchk("tx_level", 8'h80, 0);
		wr(8'h98, 0);
		for (int i = 0; i < 4; i++) begin
			v = {22'h0, i[1:0], 8'($urandom())};
			wr(8'h78, v);
			chk("rx_buf", {22'h0, rx_buf_err, rx_buf_data}, v);
		end
		rchk("readback", 8'h74, 32'h3c);
		rchk("rx_level", 8'h84, 0);
		wr(8'h70, 0);
		@(posedge mclk);
		rx_go <= 1'b1;
		@(posedge mclk);
		rx_go <= 1'b0;
		busy = 1'b1;
		wait_busy(1'b1);
		rchk("status", 8'h7c, exp_status());
		line_wr(6'h15);
		chk("line", line_settings, 0);
		busy = 1'b0;
		wait_busy(1'b0);
		v = $urandom();
		line_wr(v[5:0]);
		chk("line", line_settings, v[5:0]);
		wr(8'h98, 1);
		wr(8'h00, 32'h81);
		rchk("tx_level", 8'h80, 1);
		wr(8'ha4, 0);
		wait_busy(1'b1);
		rchk("tx_level", 8'h80, 0);
		wr(8'ha8, 1);
		chk("dma_ack", dma_ack, 1);
		@(posedge mclk);
		#1;
		chk("dma_ack", dma_ack, 0);
		wr(8'h98, 1);
		wr(8'h70, 1);
		wr(8'h8c, 1);
		wr(8'h78, 32'h1);
		wr(8'h88, 32'h1);
		chk("reset_out", uart_reset_out, 1);
		repeat (2) @(posedge mclk);
		rchk("rts", 8'h8c, 0);
		rchk("fifo_en", 8'h98, 0);
		rchk("rx_level", 8'h84, 0);
		rchk("test_ctrl", 8'h70, 0);
		stop_test();
	end
endmodule : testbench
